// ==== core/fepcs_lfsr.sv ====
module fepcs_lfsr (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Load control: while high the register takes i_load_bit.
    input wire logic i_load,
    input wire logic i_load_bit,
    // Keystream bit for the current cycle.
    output logic o_key
);
    import fepcs_pkg::*;

    logic [LFSR_W-1:0] x_q;

    assign o_key = x_q[LFSR_TAP_A] ^ x_q[LFSR_TAP_B];

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            x_q <= LFSR_SEED;
        end else begin
            x_q <= {x_q[LFSR_W-2:0], i_load ? i_load_bit : o_key};
        end
    end

    property p_keystream;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_load |=> x_q[0] == ($past(x_q[LFSR_TAP_A]) ^ $past(x_q[LFSR_TAP_B]));
    endproperty
    a_keystream: assert property (p_keystream)
        else $error("keystream bit does not follow the cipher taps");

endmodule

// ==== core/fepcs_mlt3.sv ====
module fepcs_mlt3 (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Serial NRZ bit in.
    input wire logic i_bit,
    // Three-level output: both low means the zero level.
    output logic o_pos,
    output logic o_neg
);
    import fepcs_pkg::*;

    logic [1:0] idx_q;
    logic [1:0] idx_d;

    assign idx_d = i_bit ? idx_q + 2'h1 : idx_q;

    // Index 0,1,2,3 is negative, zero, positive, zero.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idx_q <= MLT3_RST_IDX;
            o_pos <= 1'b0;
            o_neg <= 1'b0;
        end else begin
            idx_q <= idx_d;
            o_pos <= idx_d == MLT3_POS;
            o_neg <= idx_d == MLT3_NEG;
        end
    end

    property p_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_bit |=> $stable({o_pos, o_neg});
    endproperty
    a_hold: assert property (p_hold)
        else $error("line level moved on a zero bit");

    property p_step;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_bit && o_neg) |=> (!o_pos && !o_neg);
    endproperty
    a_step: assert property (p_step)
        else $error("level after negative is not zero");

endmodule

// ==== core/fepcs_pkg.sv ====
// Contract
// - MAC and coding path exchange 4-bit nibbles at a 25 MHz interface rate.
// - Transmit nibble timing is derived from the single reference clock.
// - Every transmit nibble goes to the encoder without gating or inspection; the code sends J and K in place of the first two.
// - Each data nibble maps to its fixed 5-bit data code group.
// - Idle code 11111 is sent continuously between packets.
// - First preamble byte becomes J then K; everything else is encoded alike.
// - After the last nibble, T then R is sent before idle resumes.
// - Code 10000 is reserved for flow control; other unassigned codes are invalid.
// - Coded bits are scrambled with keystream X[n] = X[n-11] xor X[n-9].
// - Scrambled code groups leave as one serial bit stream.
// - MLT-3 output holds its level on a zero bit and steps on a one.
// - MLT-3 steps cycle negative, zero, positive, zero.
// - Receive descrambler locks its LFSR to the far end during idle.
// - Carrier sense rises when two non-adjacent zeros fall in ten bits.
// - Receive data flows only after J and K are recognised, then decoded.
// - Missing J K after carrier drops carrier and signals a receive error.
// - Link loss during frame reception is a receive error.
// - An invalid received code group is a receive error.
// - Idle received before T R in a frame is a receive error.
// - Receive error rises at once and holds while the condition persists.
// - In half duplex, simultaneous transmit and receive signal a collision.
package fepcs_pkg;

    localparam int NIB_W = 4;
    localparam int GRP_W = 5;
    localparam int MII_CLK_MHZ = 25;
    localparam int LINE_RATE_MBPS = 125;
    localparam int BITS_PER_GROUP = LINE_RATE_MBPS / MII_CLK_MHZ;
    localparam logic [2:0] GRP_LAST = 3'(BITS_PER_GROUP - 1);
    localparam logic [2:0] PHASE_RST = 3'h0;

    localparam int LFSR_W = 11;
    localparam int LFSR_TAP_A = 10;
    localparam int LFSR_TAP_B = 8;
    localparam logic [10:0] LFSR_SEED = 11'h7ff;
    localparam logic [5:0] LOCK_BITS = 6'h1e;

    localparam logic [4:0] CODE_IDLE = 5'h1f;
    localparam logic [4:0] CODE_J = 5'h18;
    localparam logic [4:0] CODE_K = 5'h11;
    localparam logic [4:0] CODE_T = 5'h0d;
    localparam logic [4:0] CODE_R = 5'h07;
    localparam logic [4:0] CODE_FLOW = 5'h10;
    localparam logic [9:0] SSD_PAIR = {CODE_J, CODE_K};
    localparam logic [9:0] IDLE_RUN = 10'h3ff;
    localparam logic [3:0] SSD_WINDOW = 4'ha;

    localparam logic [1:0] MLT3_NEG = 2'h0;
    localparam logic [1:0] MLT3_POS = 2'h2;
    localparam logic [1:0] MLT3_RST_IDX = 2'h1;

    typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fepcs_tx_st_e;
    typedef enum logic [2:0] {
        RX_IDLE, RX_SSD, RX_DATA, RX_END, RX_ERR
    } fepcs_rx_st_e;

    function automatic logic [4:0] fepcs_enc(input logic [3:0] nib);
        logic [4:0] g;
        unique case (nib)
            4'h0: g = 5'h1e;
            4'h1: g = 5'h09;
            4'h2: g = 5'h14;
            4'h3: g = 5'h15;
            4'h4: g = 5'h0a;
            4'h5: g = 5'h0b;
            4'h6: g = 5'h0e;
            4'h7: g = 5'h0f;
            4'h8: g = 5'h12;
            4'h9: g = 5'h13;
            4'ha: g = 5'h16;
            4'hb: g = 5'h17;
            4'hc: g = 5'h1a;
            4'hd: g = 5'h1b;
            4'he: g = 5'h1c;
            4'hf: g = 5'h1d;
        endcase
        return g;
    endfunction

    // Returns {valid, nibble}; a group outside the data set is invalid.
    function automatic logic [4:0] fepcs_dec(input logic [4:0] g);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (fepcs_enc(4'(i)) == g) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic fepcs_sep_zeros(input logic [9:0] w);
        logic found;
        logic hit;
        int first;
        found = 1'b0;
        hit = 1'b0;
        first = 0;
        for (int i = 0; i < 10; i++) begin
            if (!w[i] && !found) begin
                found = 1'b1;
                first = i;
            end else if (!w[i] && i > first + 1) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

endpackage

// ==== core/fepcs_top.sv ====
module fepcs_top (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Transmit nibbles from the MAC.
    input wire logic i_tx_en,
    input wire logic [fepcs_pkg::NIB_W-1:0] i_txd,
    output logic o_tx_clk,
    // Receive nibbles and status to the MAC.
    output logic o_rx_clk,
    output logic [fepcs_pkg::NIB_W-1:0] o_rxd,
    output logic o_rx_dv,
    output logic o_rx_er,
    output logic o_crs,
    output logic o_col,
    // Line side, one bit per clock.
    output logic o_line_pos,
    output logic o_line_neg,
    input wire logic i_line_pos,
    input wire logic i_line_neg,
    // Link status and duplex mode pins.
    input wire logic i_link_ok,
    input wire logic i_full_duplex
);
    import fepcs_pkg::*;

    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic rx_pos;
    logic rx_neg;
    logic link_ok;
    logic full_duplex;

    logic [2:0] tx_phase_q;
    logic tx_group_end;
    fepcs_tx_st_e tx_st_q;
    logic [GRP_W-1:0] tx_sh_q;
    logic tx_key;
    logic tx_scr;
    logic tx_active;

    logic [1:0] lvl_prev_q;
    logic nrz;
    logic rx_key;
    logic rx_bit;
    logic lock_hit;
    logic locked_q;
    logic [5:0] lock_cnt_q;
    logic [9:0] hist_q;
    logic [2:0] rx_phase_q;
    logic rx_group_end;
    logic [GRP_W-1:0] rx_grp;
    logic [4:0] rx_dec;
    fepcs_rx_st_e rx_st_q;
    logic [3:0] ssd_cnt_q;
    logic ssd_match;
    logic carrier_hit;
    logic idle_seen;
    logic rx_fault;

    // Line and status pins come from the analog side and are resynchronised.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else begin
            pin_s1_q <= {i_line_pos, i_line_neg, i_link_ok, i_full_duplex};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign rx_pos = pin_s2_q[3];
    assign rx_neg = pin_s2_q[2];
    assign link_ok = pin_s2_q[1];
    assign full_duplex = pin_s2_q[0];

    // One line bit per clock; a group of five bits is one nibble time.
    assign tx_group_end = tx_phase_q == GRP_LAST;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_phase_q <= PHASE_RST;
            o_tx_clk <= 1'b0;
        end else begin
            tx_phase_q <= tx_group_end ? PHASE_RST : tx_phase_q + 3'h1;
            o_tx_clk <= tx_group_end || tx_phase_q == PHASE_RST;
        end
    end

    // The MAC drives on the rising interface clock; the nibble is taken at
    // the last bit of the group, well away from that edge.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_st_q <= TX_IDLE;
            tx_sh_q <= CODE_IDLE;
        end else if (tx_group_end) begin
            unique case (tx_st_q)
                TX_IDLE: begin
                    if (i_tx_en) begin
                        tx_st_q <= TX_K;
                        tx_sh_q <= CODE_J;
                    end else begin
                        tx_sh_q <= CODE_IDLE;
                    end
                end
                TX_K: begin
                    tx_st_q <= TX_DATA;
                    tx_sh_q <= CODE_K;
                end
                TX_DATA: begin
                    if (i_tx_en) begin
                        tx_sh_q <= fepcs_enc(i_txd);
                    end else begin
                        tx_st_q <= TX_R;
                        tx_sh_q <= CODE_T;
                    end
                end
                TX_R: begin
                    tx_st_q <= TX_IDLE;
                    tx_sh_q <= CODE_R;
                end
            endcase
        end else begin
            tx_sh_q <= {tx_sh_q[GRP_W-2:0], 1'b0};
        end
    end

    assign tx_active = i_tx_en || tx_st_q != TX_IDLE;
    assign tx_scr = tx_sh_q[GRP_W-1] ^ tx_key;

    fepcs_lfsr u_tx_lfsr (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_load(1'b0),
        .i_load_bit(1'b0),
        .o_key(tx_key)
    );

    fepcs_mlt3 u_tx_mlt3 (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_bit(tx_scr),
        .o_pos(o_line_pos),
        .o_neg(o_line_neg)
    );

    // Any change of line level is a one.
    assign nrz = {rx_pos, rx_neg} != lvl_prev_q;
    assign rx_bit = nrz ^ rx_key;
    assign lock_hit = ~nrz == rx_key;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lvl_prev_q <= 2'h0;
            hist_q <= IDLE_RUN;
        end else begin
            lvl_prev_q <= {rx_pos, rx_neg};
            hist_q <= {hist_q[8:0], rx_bit};
        end
    end

    // Until locked, the register is fed the keystream implied by idle
    // (scrambled ones); a run of correct predictions marks lock.
    fepcs_lfsr u_rx_lfsr (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_load(!locked_q),
        .i_load_bit(~nrz),
        .o_key(rx_key)
    );

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            locked_q <= 1'b0;
            lock_cnt_q <= 6'h00;
        end else if (!link_ok) begin
            locked_q <= 1'b0;
            lock_cnt_q <= 6'h00;
        end else if (!locked_q) begin
            if (!lock_hit) begin
                lock_cnt_q <= 6'h00;
            end else if (lock_cnt_q == LOCK_BITS) begin
                locked_q <= 1'b1;
            end else begin
                lock_cnt_q <= lock_cnt_q + 6'h01;
            end
        end
    end

    // Receive group timing restarts at the end of K so that groups align.
    assign ssd_match = rx_st_q == RX_SSD && hist_q == SSD_PAIR;
    assign rx_group_end = rx_phase_q == GRP_LAST;
    assign rx_grp = hist_q[GRP_W-1:0];
    assign rx_dec = fepcs_dec(rx_grp);
    // Only a fresh zero can raise carrier, so the tail of T R never does.
    assign carrier_hit = !hist_q[0] && fepcs_sep_zeros(hist_q);
    assign idle_seen = hist_q == IDLE_RUN;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_phase_q <= PHASE_RST;
            o_rx_clk <= 1'b0;
        end else begin
            if (ssd_match || rx_group_end) begin
                rx_phase_q <= PHASE_RST;
            end else begin
                rx_phase_q <= rx_phase_q + 3'h1;
            end
            o_rx_clk <= ssd_match || rx_group_end || rx_phase_q == PHASE_RST;
        end
    end

    always_comb begin
        rx_fault = 1'b0;
        if (rx_st_q == RX_SSD) begin
            rx_fault = !ssd_match && (ssd_cnt_q == SSD_WINDOW || !link_ok);
        end else if (rx_st_q == RX_DATA || rx_st_q == RX_END) begin
            rx_fault = !link_ok;
            if (rx_group_end && rx_st_q == RX_DATA && rx_grp == CODE_IDLE) begin
                rx_fault = 1'b1;
            end
            if (rx_group_end && rx_st_q == RX_END && rx_grp != CODE_R
                && rx_grp != CODE_IDLE) begin
                rx_fault = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_st_q <= RX_IDLE;
            ssd_cnt_q <= 4'h0;
            o_rxd <= 4'h0;
            o_rx_dv <= 1'b0;
            o_rx_er <= 1'b0;
            o_crs <= 1'b0;
        end else if (rx_fault) begin
            rx_st_q <= RX_ERR;
            o_rx_dv <= 1'b0;
            o_rx_er <= 1'b1;
            o_crs <= 1'b0;
        end else begin
            unique case (rx_st_q)
                RX_IDLE: begin
                    o_rx_dv <= 1'b0;
                    o_rx_er <= 1'b0;
                    ssd_cnt_q <= 4'h0;
                    if (locked_q && carrier_hit) begin
                        rx_st_q <= RX_SSD;
                        o_crs <= 1'b1;
                    end
                end
                RX_SSD: begin
                    ssd_cnt_q <= ssd_cnt_q + 4'h1;
                    if (ssd_match) begin
                        rx_st_q <= RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_group_end && rx_grp == CODE_T) begin
                        rx_st_q <= RX_END;
                        o_rx_dv <= 1'b0;
                        o_rx_er <= 1'b0;
                        o_crs <= 1'b0;
                    end else if (rx_group_end && rx_grp == CODE_FLOW) begin
                        o_rx_dv <= 1'b0;
                        o_rx_er <= 1'b0;
                    end else if (rx_group_end) begin
                        o_rxd <= rx_dec[3:0];
                        o_rx_dv <= 1'b1;
                        o_rx_er <= !rx_dec[4];
                    end
                end
                RX_END: begin
                    if (rx_group_end) begin
                        rx_st_q <= RX_IDLE;
                    end
                end
                RX_ERR: begin
                    o_rx_dv <= 1'b0;
                    if (idle_seen && link_ok) begin
                        rx_st_q <= RX_IDLE;
                        o_rx_er <= 1'b0;
                    end else begin
                        o_rx_er <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_col <= 1'b0;
        end else begin
            o_col <= !full_duplex && tx_active && o_crs;
        end
    end

    sequence s_jk;
        tx_sh_q == CODE_J ##5 tx_sh_q == CODE_K;
    endsequence

    sequence s_tr;
        tx_sh_q == CODE_T ##5 tx_sh_q == CODE_R;
    endsequence

    property p_idle_fill;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (tx_group_end && tx_st_q == TX_IDLE && !i_tx_en)
            |=> tx_sh_q == CODE_IDLE;
    endproperty
    a_idle_fill: assert property (p_idle_fill)
        else $error("idle code missing between packets");

    property p_start_pair;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (tx_group_end && tx_st_q == TX_IDLE && i_tx_en) |=> s_jk;
    endproperty
    a_start_pair: assert property (p_start_pair)
        else $error("frame did not open with J then K");

    property p_end_pair;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (tx_group_end && tx_st_q == TX_DATA && !i_tx_en) |=> s_tr;
    endproperty
    a_end_pair: assert property (p_end_pair)
        else $error("frame did not close with T then R");

    property p_data_code;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (tx_group_end && tx_st_q == TX_DATA && i_tx_en)
            |=> tx_sh_q == fepcs_enc($past(i_txd));
    endproperty
    a_data_code: assert property (p_data_code)
        else $error("data nibble encoded to the wrong group");

    property p_collision;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (!full_duplex && tx_active && o_crs) |=> o_col;
    endproperty
    a_collision: assert property (p_collision)
        else $error("collision not signalled in half duplex");

    property p_no_col_fdx;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        full_duplex |=> !o_col;
    endproperty
    a_no_col_fdx: assert property (p_no_col_fdx)
        else $error("collision signalled in full duplex");

    property p_carrier;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (rx_st_q == RX_IDLE && locked_q && carrier_hit) |=> o_crs;
    endproperty
    a_carrier: assert property (p_carrier)
        else $error("carrier sense late");

    property p_false_carrier;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (rx_st_q == RX_SSD && !ssd_match && ssd_cnt_q == SSD_WINDOW)
            |=> (!o_crs && o_rx_er);
    endproperty
    a_false_carrier: assert property (p_false_carrier)
        else $error("false carrier not reported");

    property p_link_loss;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        ((rx_st_q == RX_DATA || rx_st_q == RX_END) && !link_ok) |=> o_rx_er;
    endproperty
    a_link_loss: assert property (p_link_loss)
        else $error("link loss in frame not reported");

    property p_no_data_before_ssd;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        rx_st_q == RX_SSD |-> !o_rx_dv;
    endproperty
    a_no_data_before_ssd: assert property (p_no_data_before_ssd)
        else $error("receive data valid before start pair");

    property p_error_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (rx_st_q == RX_ERR && !(idle_seen && link_ok)) |=> o_rx_er;
    endproperty
    a_error_hold: assert property (p_error_hold)
        else $error("receive error dropped while condition persists");

endmodule

// ==== sim/fepcs_mac_model.sv ====
module fepcs_mac_model (
    // Clocks.
    input wire logic i_ref_clk,
    input wire logic i_tx_clk,
    // Transmit side.
    output logic o_tx_en,
    output logic [3:0] o_txd,
    // Receive side.
    input wire logic i_rx_dv,
    input wire logic [3:0] i_rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] tx_q[$];
    logic [3:0] rx_q[$];
    logic clk_p = 1'b0;
    int cnt = 0;

    initial o_tx_en = 1'b0;
    initial o_txd = 4'h0;

    task automatic send(input logic [3:0] nib);
        tx_q.push_back(nib);
    endtask

    // A nibble changes only one clock after the interface clock rises, so it is steady
    // when the group end samples it; idle data toggles so it is not stale.
    always @(posedge i_ref_clk) begin
        clk_p <= i_tx_clk;
        if (i_tx_clk && !clk_p) begin
            o_tx_en <= (tx_q.size() > 0);
            if (tx_q.size() > 0)
                o_txd <= tx_q.pop_front();
            else
                o_txd <= ~o_txd;
        end
    end

    // One nibble per five-cycle group while receive data is valid.
    always @(posedge i_ref_clk) begin
        if (!i_rx_dv) begin
            cnt <= 0;
        end else begin
            if (cnt == 0)
                rx_q.push_back(i_rxd);
            cnt <= (cnt == 4) ? 0 : cnt + 1;
        end
    end
endmodule

// ==== sim/test_fast_ethernet_pcs_coding.sv ====
module test_fast_ethernet_pcs_coding;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic link_ok = 1'b1;
    logic fdx = 1'b0;
    logic flip = 1'b0;
    logic lp = 1'b0;
    logic ln = 1'b0;
    logic tx_en, tx_clk, rx_clk, rx_dv, rx_er, crs, col, op, on;
    logic [3:0] txd, rxd;
    logic [1:0] lvl, lvl_p = 2'h0, last_nz = 2'h0, idx = 2'h1;
    logic [10:0] key = 11'h0;
    logic [9:0] w = 10'h0;
    logic b, pred, lk = 1'b0, cap = 1'b0;
    logic s_crs = 1'b0, s_col = 1'b0, s_er = 1'b0;
    logic [4:0] grp_q[$];
    int gcnt = -1, mlt_bad = 0, fail_count = 0, checks = 0;
    logic [4:0] enc_t [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
        5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c,
        5'h1d};

    fepcs_top dut_u (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_tx_en(tx_en), .i_txd(txd),
        .o_tx_clk(tx_clk), .o_rx_clk(rx_clk), .o_rxd(rxd), .o_rx_dv(rx_dv),
        .o_rx_er(rx_er), .o_crs(crs), .o_col(col), .o_line_pos(op),
        .o_line_neg(on), .i_line_pos(lp), .i_line_neg(ln),
        .i_link_ok(link_ok), .i_full_duplex(fdx)
    );
    fepcs_mac_model mac_u (
        .i_ref_clk(clk), .i_tx_clk(tx_clk), .o_tx_en(tx_en), .o_txd(txd),
        .i_rx_dv(rx_dv), .i_rxd(rxd)
    );

    // Line monitor: decodes MLT-3, descrambles with its own keystream and
    // loops the line back through an own MLT-3 encoder. Flip inverts bits
    // on the way back, which is the only way to corrupt descrambled data.
    always @(posedge clk) begin
        lvl = {op, on};
        b = (lvl != lvl_p);
        if (lvl == 2'h3 || (lvl != 2'h0 && lvl_p != 2'h0 && lvl != lvl_p)
            || (lvl != 2'h0 && lvl_p == 2'h0 && lvl == last_nz))
            mlt_bad++;
        if (lvl != 2'h0)
            last_nz = lvl;
        lvl_p = lvl;
        pred = key[10] ^ key[8];
        key = {key[9:0], lk ? pred : ~b};
        w = {w[8:0], b ^ pred};
        if (gcnt >= 0) begin
            gcnt++;
            if (gcnt == 5) begin
                grp_q.push_back(w[4:0]);
                gcnt = (grp_q.size() == 19) ? -1 : 0;
            end
        end else if (cap && w == 10'h311) begin
            gcnt = 0;
        end
        s_crs |= crs;
        s_col |= col;
        s_er |= rx_er;
        if (b ^ flip)
            idx = idx + 2'h1;
        lp <= (idx == 2'h2);
        ln <= (idx == 2'h0);
    end

    task automatic check(input string nm, input logic [4:0] seen,
                         input logic [4:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic clr();
        @(negedge clk);
        s_crs = 1'b0;
        s_col = 1'b0;
        s_er = 1'b0;
    endtask

    task automatic frame(input logic zero);
        mac_u.send(4'h5);
        mac_u.send(4'h5);
        for (int i = 0; i < 16; i++)
            mac_u.send(zero ? 4'h0 : 4'(i));
    endtask

    task automatic t_frame(input logic fd);
        int n, hi_t, hi_r;
        n = 0;
        hi_t = 0;
        hi_r = 0;
        @(posedge clk);
        fdx <= fd;
        repeat (10) @(posedge clk);
        clr();
        grp_q.delete();
        mac_u.rx_q.delete();
        cap = 1'b1;
        frame(1'b0);
        while (grp_q.size() < 19 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n == 400) begin
            fail_count++;
            close_out();
        end
        repeat (40) @(posedge clk);
        cap <= 1'b0;
        // Both interface clocks are high two cycles of every five.
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            hi_t += int'(tx_clk);
            hi_r += int'(rx_clk);
        end
        check("tx_clk", 5'(hi_t), 5'h04);
        check("rx_clk", 5'(hi_r), 5'h04);
        for (int i = 0; i < 16; i++)
            check("code", grp_q[i], enc_t[i]);
        check("jk", 5'(grp_q.size()), 5'h13);
        check("end_t", grp_q[16], 5'h0d);
        check("end_r", grp_q[17], 5'h07);
        check("idle", grp_q[18], 5'h1f);
        check("mlt3", 5'(mlt_bad != 0), 5'h00);
        check("rx_n", 5'(mac_u.rx_q.size()), 5'h10);
        for (int i = 0; i < 16; i++)
            check("rxd", 5'(mac_u.rx_q[i]), 5'(i));
        check("crs_seen", 5'(s_crs), 5'h01);
        check("crs_end", 5'(crs), 5'h00);
        check("er", 5'(s_er), 5'h00);
        check("col", 5'(s_col), 5'(!fd));
    endtask

    // Mode 0 false carrier in idle, 1 bit errors in a frame, 2 link loss.
    task automatic t_err(input int mode);
        clr();
        if (mode > 0)
            frame(1'b1);
        repeat (40) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            if (mode == 2)
                link_ok <= 1'b0;
            else
                flip <= (mode == 1) || (i[0] == 1'b0);
            @(posedge clk);
        end
        flip <= 1'b0;
        link_ok <= 1'b1;
        repeat (30) @(posedge clk);
        check("er_seen", 5'(s_er), 5'h01);
        if (mode == 0)
            check("crs_fc", 5'(crs), 5'h00);
        repeat (300) @(posedge clk);
        check("er_end", 5'(rx_er), 5'h00);
    endtask

    initial forever #10 clk = ~clk;

    initial begin
        repeat (10) @(posedge clk);
        check("reset", {crs, rx_dv, rx_er, col, op}, 5'h00);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (100) @(posedge clk);
        lk <= 1'b1;
        repeat (200) @(posedge clk);
        t_frame(1'b0);
        t_frame(1'b1);
        for (int m = 0; m < 3; m++)
            t_err(m);
        close_out();
    end
endmodule
